// file: src/arce_engine.sv
// Purpose: read-class command engine behind the task-file registers.
// Assumes: the media side answers each fetch with one done pulse and a result.
// Notes: data port reads pop the sector buffer; interrupt status clears on read.
module arce_engine
  import arce_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [15:0] RDATA,
  output logic             MEDIA_GO,
  output logic      [27:0] MEDIA_LBA,
  output logic             MEDIA_LONG,
  input  wire logic        MEDIA_DONE,
  input  wire logic [2:0]  MEDIA_ERR,
  input  wire logic [15:0] MEDIA_WORD,
  input  wire logic [7:0]  MEDIA_BYTE,
  output logic      [8:0]  MEDIA_INDEX,
  output logic             IRQ
);
  arce_media_if m ();
  arce_err_map u_map (.m(m));

  arce_state_type state;
  logic [7:0]  feature_select;
  logic [7:0]  transfer_count;
  logic [7:0]  address_low_byte;
  logic [7:0]  address_mid_byte;
  logic [7:0]  address_high_byte;
  logic [7:0]  unit_head_select;
  logic [7:0]  opcode;
  logic [7:0]  error_reg;
  logic [7:0]  ext_error;
  logic [8:0]  remaining;
  logic [8:0]  word_index;
  logic        busy;
  logic        drq;
  logic        err_flag;
  logic        is_long;
  logic        is_verify;
  logic        first;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic        media_enable;
  logic        ev_sector;
  logic        ev_done;
  logic [27:0] cur_lba;
  logic [27:0] next_lba;
  logic [15:0] next_rdata;
  logic        data_pop;
  logic        op_write;

  assign m.fetch_go   = MEDIA_GO;
  assign m.fetch_long = is_long;
  assign m.fetch_done = MEDIA_DONE;
  assign m.fetch_code = MEDIA_ERR;
  assign op_write     = WR && ADDR == ADDR_OPCODE && state == ARCE_IDLE;
  assign data_pop     = RD && ADDR == ADDR_DATA && drq;

  // chs and lba forms both advance as one flat 28-bit count; the mode bit is not consulted
  assign cur_lba = {unit_head_select[3:0], address_high_byte, address_mid_byte,
                    address_low_byte};
  always_comb begin
    next_lba = cur_lba + 28'h1;
  end

  assign MEDIA_LBA   = cur_lba;
  assign MEDIA_LONG  = is_long;
  assign MEDIA_INDEX = word_index;
  assign IRQ         = |(irq_status & irq_mask);

  // command sequencer
  always_ff @(posedge MCLK) begin
    ev_sector <= 1'b0;
    ev_done   <= 1'b0;
    MEDIA_GO  <= 1'b0;
    if (RESET) begin
      state      <= ARCE_IDLE;
      busy       <= 1'b0;
      drq        <= 1'b0;
      err_flag   <= 1'b0;
      is_long    <= 1'b0;
      is_verify  <= 1'b0;
      first      <= 1'b0;
      remaining  <= 9'h000;
      word_index <= 9'h000;
      error_reg  <= RESET_BYTE;
      ext_error  <= XE_NONE;
      opcode     <= RESET_BYTE;
    end else begin
      case (state)
        ARCE_IDLE: begin
          if (op_write) begin
            opcode    <= WDATA[7:0];
            err_flag  <= 1'b0;
            error_reg <= RESET_BYTE;
            first     <= 1'b1;
            is_long   <= WDATA[7:0] == OP_LONG_A || WDATA[7:0] == OP_LONG_B;
            is_verify <= WDATA[7:0] == OP_VERIFY_A || WDATA[7:0] == OP_VERIFY_B;
            if (WDATA[7:0] == OP_LONG_A || WDATA[7:0] == OP_LONG_B) begin
              remaining <= 9'h001;
              busy      <= 1'b1;
              state     <= ARCE_FETCH;
            end else if (WDATA[7:0] == OP_READ_A || WDATA[7:0] == OP_READ_B ||
                         WDATA[7:0] == OP_VERIFY_A || WDATA[7:0] == OP_VERIFY_B) begin
              remaining <= (transfer_count == 8'h00) ? SECTOR_WORDS
                                                     : {1'b0, transfer_count};
              busy      <= 1'b1;
              state     <= ARCE_FETCH;
            end else if (WDATA[7:0] == OP_SENSE) begin
              error_reg <= ext_error;
              ext_error <= XE_NONE;
              ev_done   <= 1'b1;
            end else if (WDATA[7:4] == OP_RECAL_HI) begin
              ext_error <= XE_NONE;
              ev_done   <= 1'b1;
            end else begin
              err_flag  <= 1'b1;
              error_reg <= 8'h01 << ERR_ABORT_BIT;
              ext_error <= XE_INVALID_CMD;
              ev_done   <= 1'b1;
            end
          end
        end
        ARCE_FETCH: begin
          if (!media_enable) begin
            err_flag  <= 1'b1;
            error_reg <= 8'h01 << ERR_ABORT_BIT;
            ext_error <= XE_ABORTED;
            busy      <= 1'b0;
            ev_done   <= 1'b1;
            state     <= ARCE_IDLE;
          end else begin
            MEDIA_GO <= 1'b1;
            state    <= ARCE_WAIT;
          end
        end
        ARCE_WAIT: begin
          if (MEDIA_DONE) begin
            first     <= 1'b0;
            remaining <= remaining - 9'h001;
            ext_error <= m.ext_code;
            if (m.hard_fail) begin
              err_flag  <= 1'b1;
              error_reg <= (MEDIA_ERR == MERR_ID_MISS) ? 8'h01 << ERR_IDNF_BIT
                                                        : 8'h01 << ERR_UNC_BIT;
            end
            if (is_verify) begin
              if (m.hard_fail || remaining == 9'h001) begin
                busy    <= 1'b0;
                ev_done <= 1'b1;
                state   <= ARCE_IDLE;
              end else begin
                state <= ARCE_FETCH;
              end
            end else begin
              word_index <= 9'h000;
              busy       <= 1'b0;
              drq        <= 1'b1;
              ev_sector  <= 1'b1;
              state      <= ARCE_XFER;
            end
          end
        end
        ARCE_XFER: begin
          if (data_pop) begin
            word_index <= word_index + 9'h001;
            if (word_index == SECTOR_WORDS - 9'h001) begin
              word_index <= 9'h000;
              if (is_long) begin
                state <= ARCE_TAIL;
              end else if (err_flag || remaining == 9'h000) begin
                drq   <= 1'b0;
                state <= ARCE_IDLE;
              end else begin
                drq   <= 1'b0;
                busy  <= 1'b1;
                state <= ARCE_FETCH;
              end
            end
          end
        end
        ARCE_TAIL: begin
          if (data_pop) begin
            word_index <= word_index + 9'h001;
            if (word_index == {6'h00, LONG_BYTES} - 9'h001) begin
              drq   <= 1'b0;
              state <= ARCE_IDLE;
            end
          end
        end
        default: state <= ARCE_IDLE;
      endcase
    end
  end

  // task-file address and count registers; hardware updates beat host writes
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      feature_select    <= RESET_BYTE;
      transfer_count    <= RESET_LOW;
      address_low_byte  <= RESET_LOW;
      address_mid_byte  <= RESET_BYTE;
      address_high_byte <= RESET_BYTE;
      unit_head_select  <= RESET_UNIT;
    end else begin
      if (WR && state == ARCE_IDLE) begin
        case (ADDR)
          ADDR_FEATURE: feature_select    <= WDATA[7:0];
          ADDR_COUNT:   transfer_count    <= WDATA[7:0];
          ADDR_LOW:     address_low_byte  <= WDATA[7:0];
          ADDR_MID:     address_mid_byte  <= WDATA[7:0];
          ADDR_HIGH:    address_high_byte <= WDATA[7:0];
          ADDR_UNIT:    unit_head_select  <= WDATA[7:0];
          default: ;
        endcase
      end
      if (op_write && WDATA[7:4] == OP_RECAL_HI) begin
        address_mid_byte       <= RESET_BYTE;
        address_high_byte      <= RESET_BYTE;
        unit_head_select[3:0]  <= 4'h0;
        address_low_byte       <= unit_head_select[UNIT_LBA_BIT] ? RESET_BYTE : RESET_LOW;
      end
      if (state == ARCE_WAIT && MEDIA_DONE) begin
        if (is_verify && m.hard_fail) begin
          transfer_count <= remaining[7:0];
        end
        if (!m.hard_fail && remaining != 9'h001) begin
          // advance only when another sector follows, so the last one stays
          {unit_head_select[3:0], address_high_byte, address_mid_byte,
           address_low_byte} <= next_lba;
        end
      end
    end
  end

  // interrupt status: bit0 sector ready, bit1 command done; read clears, set wins
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      irq_status   <= 2'h0;
      irq_mask     <= RESET_MASK;
      media_enable <= 1'b1;
    end else begin
      if (WR && ADDR == ADDR_IRQ_MASK) begin
        irq_mask <= WDATA[1:0];
      end
      if (WR && ADDR == ADDR_MEDIA_CTRL) begin
        media_enable <= WDATA[0];
      end
      irq_status <= ((RD && ADDR == ADDR_IRQ_STATUS) ? 2'h0 : irq_status)
                    | {ev_done, ev_sector};
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    case (ADDR)
      ADDR_DATA:       next_rdata = (state == ARCE_TAIL) ? {8'h00, MEDIA_BYTE}
                                                         : MEDIA_WORD;
      ADDR_FEATURE:    next_rdata = {8'h00, error_reg};
      ADDR_COUNT:      next_rdata = {8'h00, transfer_count};
      ADDR_LOW:        next_rdata = {8'h00, address_low_byte};
      ADDR_MID:        next_rdata = {8'h00, address_mid_byte};
      ADDR_HIGH:       next_rdata = {8'h00, address_high_byte};
      ADDR_UNIT:       next_rdata = {8'h00, unit_head_select};
      ADDR_OPCODE:     next_rdata = {8'h00, busy, ~busy, 2'b00, drq, 2'b00, err_flag};
      ADDR_IRQ_STATUS: next_rdata = {14'h0000, irq_status};
      ADDR_IRQ_MASK:   next_rdata = {14'h0000, irq_mask};
      ADDR_MEDIA_CTRL: next_rdata = {15'h0000, media_enable};
      default:         next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 16'h0000;
    end
  end
endmodule : arce_engine

// file: src/arce_pkg.sv
// Purpose: constants and types shared by the read-class command engine.
// Assumes: one clock MCLK at 250 MHz, synchronous active-high RESET.
// Notes: task-file registers sit at their printed offsets on a plain port.
package arce_pkg;
  localparam logic [3:0] ADDR_DATA       = 4'h0;
  localparam logic [3:0] ADDR_FEATURE    = 4'h1;
  localparam logic [3:0] ADDR_COUNT      = 4'h2;
  localparam logic [3:0] ADDR_LOW        = 4'h3;
  localparam logic [3:0] ADDR_MID        = 4'h4;
  localparam logic [3:0] ADDR_HIGH       = 4'h5;
  localparam logic [3:0] ADDR_UNIT       = 4'h6;
  localparam logic [3:0] ADDR_OPCODE     = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'h9;
  localparam logic [3:0] ADDR_MEDIA_CTRL = 4'hA;

  localparam int          UNIT_LBA_BIT  = 6;
  localparam int          ST_BUSY_BIT   = 7;
  localparam int          ST_READY_BIT  = 6;
  localparam int          ST_DRQ_BIT    = 3;
  localparam int          ST_ERR_BIT    = 0;
  localparam int          ERR_ABORT_BIT = 2;
  localparam int          ERR_UNC_BIT   = 6;
  localparam int          ERR_IDNF_BIT  = 4;
  localparam logic [8:0]  SECTOR_WORDS  = 9'h100;
  localparam logic [2:0]  LONG_BYTES    = 3'h4;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [7:0]  RESET_LOW     = 8'h01;
  localparam logic [7:0]  RESET_UNIT    = 8'hA0;
  localparam logic [1:0]  RESET_MASK    = 2'h3;

  localparam logic [7:0] OP_READ_A   = 8'h20;
  localparam logic [7:0] OP_READ_B   = 8'h21;
  localparam logic [7:0] OP_LONG_A   = 8'h22;
  localparam logic [7:0] OP_LONG_B   = 8'h23;
  localparam logic [7:0] OP_VERIFY_A = 8'h40;
  localparam logic [7:0] OP_VERIFY_B = 8'h41;
  localparam logic [3:0] OP_RECAL_HI = 4'h1;
  localparam logic [7:0] OP_SENSE    = 8'h03;

  localparam logic [7:0] XE_NONE        = 8'h00;
  localparam logic [7:0] XE_SELFTEST_OK = 8'h01;
  localparam logic [7:0] XE_MISC        = 8'h09;
  localparam logic [7:0] XE_INVALID_CMD = 8'h20;
  localparam logic [7:0] XE_INVALID_ADR = 8'h21;
  localparam logic [7:0] XE_OVERFLOW    = 8'h2F;
  localparam logic [7:0] XE_VOLTAGE     = 8'h35;
  localparam logic [7:0] XE_UNCORRECT   = 8'h11;
  localparam logic [7:0] XE_CORRECTED   = 8'h18;
  localparam logic [7:0] XE_ID_MISSING  = 8'h10;
  localparam logic [7:0] XE_ABORTED     = 8'h1F;
  localparam logic [7:0] XE_SELFTEST_NG = 8'h05;
  localparam logic [7:0] XE_SPARES_OUT  = 8'h3A;
  localparam logic [7:0] XE_BAD_FORMAT  = 8'h0C;
  localparam logic [7:0] XE_WRITE_FAIL  = 8'h03;

  localparam logic [2:0] MERR_CORRECTED = 3'h1;
  localparam logic [2:0] MERR_UNCORRECT = 3'h2;
  localparam logic [2:0] MERR_ID_MISS   = 3'h3;
  localparam logic [2:0] MERR_FORMAT    = 3'h4;
  localparam logic [2:0] MERR_VOLTAGE   = 3'h5;
  localparam logic [2:0] MERR_SPARES    = 3'h6;
  localparam logic [2:0] MERR_OTHER     = 3'h7;

  typedef enum logic [2:0] {
    ARCE_IDLE  = 3'b000,
    ARCE_FETCH = 3'b001,
    ARCE_WAIT  = 3'b010,
    ARCE_XFER  = 3'b011,
    ARCE_TAIL  = 3'b100
  } arce_state_type;
endpackage : arce_pkg

// file: src/arce_media_if.sv
// Purpose: fetch handshake between the sequencer and the media error map.
// Assumes: one request in flight at a time.
// Notes: fetch_code is the raw media result, zero when clean.
interface arce_media_if;
  logic       fetch_go;
  logic       fetch_long;
  logic       fetch_done;
  logic [2:0] fetch_code;
  logic [7:0] ext_code;
  logic       hard_fail;
  modport seq (output fetch_go, output fetch_long, input fetch_done, input fetch_code,
               input ext_code, input hard_fail);
  modport map (input fetch_go, input fetch_long, input fetch_done, input fetch_code,
               output ext_code, output hard_fail);
endinterface : arce_media_if

// file: src/arce_err_map.sv
// Purpose: turn a media result into an extended error code and a stop flag.
// Assumes: fetch_code is stable while fetch_done is high.
// Notes: a corrected error does not stop the read; it is reported except on long reads.
module arce_err_map
  import arce_pkg::*;
(
  arce_media_if.map m
);
  always_comb begin
    m.hard_fail = 1'b1;
    case (m.fetch_code)
      3'h0:           m.ext_code = XE_NONE;
      MERR_CORRECTED: begin
        m.ext_code  = m.fetch_long ? XE_NONE : XE_CORRECTED;
        m.hard_fail = 1'b0;
      end
      MERR_UNCORRECT: m.ext_code = XE_UNCORRECT;
      MERR_ID_MISS:   m.ext_code = XE_ID_MISSING;
      MERR_FORMAT:    m.ext_code = XE_BAD_FORMAT;
      MERR_VOLTAGE:   m.ext_code = XE_VOLTAGE;
      MERR_SPARES:    m.ext_code = XE_SPARES_OUT;
      default:        m.ext_code = XE_MISC;
    endcase
    if (m.fetch_code == 3'h0) begin
      m.hard_fail = 1'b0;
    end
    if (m.fetch_long && m.fetch_code == MERR_UNCORRECT) begin
      m.ext_code  = XE_NONE;
      m.hard_fail = 1'b0;
    end
  end
endmodule : arce_err_map

// file: verif/arce_engine_chk.sv
// Purpose: port-level checks on the read-class command engine.
// Assumes: the media side answers a fetch no sooner than four cycles later.
// Notes: bound to the engine from the testbench file.
module arce_engine_chk
  import arce_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic [3:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [15:0] RDATA,
  input wire logic        MEDIA_GO,
  input wire logic [27:0] MEDIA_LBA,
  input wire logic        MEDIA_LONG,
  input wire logic [15:0] MEDIA_WORD,
  input wire logic [8:0]  MEDIA_INDEX,
  input wire logic        IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] long_gos;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // fetches issued since the current long command was written
  always_ff @(posedge MCLK) begin
    if (RESET || !MEDIA_LONG || (WR && ADDR == ADDR_OPCODE))
      long_gos <= 2'h0;
    else if (MEDIA_GO && long_gos != 2'h3)
      long_gos <= long_gos + 2'h1;
  end
  sequence s_mask_off;
    WR && ADDR == ADDR_IRQ_MASK && WDATA[1:0] == 2'h0 ##1 !(WR && ADDR == ADDR_IRQ_MASK);
  endsequence
  sequence s_pop;
    RD && ADDR == ADDR_DATA && !MEDIA_LONG ##1 MEDIA_INDEX == $past(MEDIA_INDEX) + 9'h1;
  endsequence
  property p_mask_quiet; s_mask_off |=> !IRQ; endproperty
  property p_pop_data; s_pop |-> RDATA == $past(MEDIA_WORD); endproperty
  property p_go_hold; MEDIA_GO |=> (!MEDIA_GO && $stable(MEDIA_LBA))[*3]; endproperty
  property p_index_step;
    !$stable(MEDIA_INDEX) |-> MEDIA_INDEX == 9'h0 ||
      (MEDIA_INDEX == $past(MEDIA_INDEX) + 9'h1 && $past(RD) && $past(ADDR) == ADDR_DATA);
  endproperty
  property p_rdata_idle; !RD |=> RDATA == 16'h0; endproperty
  property p_unmapped; RD && ADDR > ADDR_MEDIA_CTRL |=> RDATA == 16'h0; endproperty
  property p_lba_reset; disable iff (1'b0) RESET |=> MEDIA_LBA == 28'h0000001; endproperty
  property p_long_single; MEDIA_LONG |-> long_gos <= 2'h1; endproperty
  a_mask_quiet: assert property (p_mask_quiet)
    else $error("irq high with mask cleared");
  a_pop_data: assert property (p_pop_data)
    else $error("data word differs from buffer");
  a_go_hold: assert property (p_go_hold)
    else $error("fetch address moved or second fetch");
  a_index_step: assert property (p_index_step)
    else $error("buffer index jumped");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data without read");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_lba_reset: assert property (p_lba_reset)
    else $error("address not at reset value");
  a_long_single: assert property (p_long_single)
    else $error("long read fetched twice");
endmodule : arce_engine_chk

// file: verif/arce_media_model.sv
// Purpose: media-side model: sector buffer and fetch answers.
// Assumes: one fetch outstanding; error only on the fetch numbered err_at.
// Notes: err carries a rolling pattern outside done cycles.
module arce_media_model (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        go,
  input  wire logic [27:0] lba,
  input  wire logic [8:0]  index,
  input  wire logic [8:0]  err_at,
  input  wire logic [2:0]  err_code,
  output logic             done,
  output logic      [2:0]  err,
  output logic      [15:0] word,
  output logic      [7:0]  tail,
  output logic      [8:0]  go_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  logic [7:0] held;
  logic [2:0] roll;
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      wait_cnt <= 4'h0;
      done     <= 1'b0;
      go_count <= 9'h0;
      roll     <= 3'h0;
    end else begin
      roll <= roll + 3'h1;
      done <= wait_cnt == 4'h1;
      if (go) begin
        wait_cnt <= 4'h4 + 4'($urandom & 7);
        held     <= lba[7:0];
        go_count <= go_count + 9'h1;
      end else if (wait_cnt != 4'h0)
        wait_cnt <= wait_cnt - 4'h1;
    end
  end
  assign err  = done ? (go_count == err_at ? err_code : 3'h0) : roll;
  assign word = {index[7:0], held};
  assign tail = 8'hF0 ^ index[7:0];
endmodule : arce_media_model

// file: verif/testbench.sv
// Purpose: self-checking bench for the read-class command engine.
// Assumes: media model answers each fetch after 4 to 11 cycles.
// Notes: random start addresses from a fixed seed.
module testbench
  import arce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        MCLK, RESET, WR, RD, MEDIA_GO, MEDIA_LONG, MEDIA_DONE, IRQ;
  logic [3:0]  ADDR;
  logic [15:0] WDATA, RDATA, MEDIA_WORD, v;
  logic [27:0] MEDIA_LBA, lba;
  logic [2:0]  MEDIA_ERR, err_code;
  logic [7:0]  MEDIA_BYTE;
  logic [8:0]  MEDIA_INDEX, err_at, go_count;
  int          n_mismatch, cmp_count;
  arce_engine arce_engine_inst (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .MEDIA_GO(MEDIA_GO), .MEDIA_LBA(MEDIA_LBA),
    .MEDIA_LONG(MEDIA_LONG), .MEDIA_DONE(MEDIA_DONE), .MEDIA_ERR(MEDIA_ERR),
    .MEDIA_WORD(MEDIA_WORD), .MEDIA_BYTE(MEDIA_BYTE), .MEDIA_INDEX(MEDIA_INDEX), .IRQ(IRQ));
  arce_media_model arce_media_model_inst (.MCLK(MCLK), .RESET(RESET), .go(MEDIA_GO),
    .lba(MEDIA_LBA), .index(MEDIA_INDEX), .err_at(err_at), .err_code(err_code),
    .done(MEDIA_DONE), .err(MEDIA_ERR), .word(MEDIA_WORD), .tail(MEDIA_BYTE),
    .go_count(go_count));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge MCLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  task automatic wait_irq(input logic [15:0] exp);
    for (int i = 0; i < 8000 && IRQ !== 1'b1; i++) @(posedge MCLK);
    rd(ADDR_IRQ_STATUS, v);
    chk("irq status", exp, v);
  endtask : wait_irq
  task automatic cmd(input logic [7:0] op, input logic [7:0] cnt, input logic [27:0] a,
                     input logic [3:0] mode);
    rd(ADDR_IRQ_STATUS, v);
    wr(ADDR_COUNT, {8'h0, cnt});
    wr(ADDR_LOW, {8'h0, a[7:0]});
    wr(ADDR_MID, {8'h0, a[15:8]});
    wr(ADDR_HIGH, {8'h0, a[23:16]});
    wr(ADDR_UNIT, {8'h0, mode, a[27:24]});
    wr(ADDR_OPCODE, {8'h0, op});
  endtask : cmd
  task automatic chk_addr(input logic [27:0] a);
    logic [31:0] g;
    g = 32'h0;
    for (int k = 0; k < 4; k++) begin
      rd(ADDR_LOW + 4'(k), v);
      g[8*k +: 8] = v[7:0];
    end
    chk("address", {4'h0, a}, {4'h0, g[27:0]});
  endtask : chk_addr
  task automatic take_sector(input logic [27:0] a, input bit long_tail);
    for (int i = 0; i < 256; i++) begin
      rd(ADDR_DATA, v);
      chk("word", {i[7:0], a[7:0]}, v);
    end
    for (int i = 0; i < 4 && long_tail; i++) begin
      rd(ADDR_DATA, v);
      chk("tail byte", 8'hF0 ^ i[7:0], v[7:0]);
    end
  endtask : take_sector
  task automatic sense(input logic [7:0] code);
    rd(ADDR_IRQ_STATUS, v);
    wr(ADDR_OPCODE, {8'h0, OP_SENSE});
    wait_irq(16'h0002);
    rd(ADDR_FEATURE, v);
    chk("extended code", code, v);
  endtask : sense
  function automatic logic [15:0] reset_val(input logic [3:0] a);
    case (a)
      ADDR_COUNT, ADDR_LOW: return 16'h0001;
      ADDR_UNIT:            return 16'h00A0;
      ADDR_IRQ_MASK:        return 16'h0003;
      default:              return 16'h0000;
    endcase
  endfunction : reset_val
  function automatic logic [7:0] xe_of(input logic [2:0] m);
    case (m)
      MERR_UNCORRECT: return XE_UNCORRECT;
      MERR_ID_MISS:   return XE_ID_MISSING;
      MERR_FORMAT:    return XE_BAD_FORMAT;
      MERR_VOLTAGE:   return XE_VOLTAGE;
      MERR_SPARES:    return XE_SPARES_OUT;
      default:        return XE_MISC;
    endcase
  endfunction : xe_of
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    RESET = 1'b1;
    {WR, RD, ADDR, WDATA, err_at, err_code} = '0;
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(32'hC2FB));
    repeat (4) @(posedge MCLK);
    RESET <= 1'b0;
    for (int a = 2; a < 16; a++) begin
      if (a == 7 || a == 10) continue;
      rd(4'(a), v);
      chk("reset value", reset_val(4'(a)), v);
    end
    for (int k = 0; k < 2; k++) begin
      lba = {4'h0, 24'($urandom)};
      cmd(k ? OP_READ_B : OP_READ_A, 8'h02, lba, 4'hE);
      for (int s = 0; s < 2; s++) begin
        wait_irq(16'h0001);
        rd(ADDR_OPCODE, v);
        chk("status", 16'h0048, v & 16'h00C9);
        take_sector(lba + 28'(s), 1'b0);
      end
      chk_addr(lba + 28'h1);
    end
    for (int k = 0; k < 3; k++) begin
      err_code <= k ? MERR_UNCORRECT : MERR_CORRECTED;
      lba = 28'($urandom);
      err_at <= go_count + 9'h1;
      cmd(k == 2 ? OP_READ_B : k ? OP_LONG_B : OP_LONG_A, 8'h03, lba, 4'hE);
      wait_irq(16'h0001);
      rd(ADDR_OPCODE, v);
      chk("data status", k == 2 ? 16'h0049 : 16'h0048, v & 16'h00C9);
      rd(ADDR_FEATURE, v);
      chk("error bits", k == 2 ? 16'h0040 : 16'h0000, v & 16'h0054);
      take_sector(lba, k != 2);
      rd(ADDR_OPCODE, v);
      chk("end status", k == 2 ? 16'h0041 : 16'h0040, v & 16'h00C9);
      chk_addr(lba);
      if (k == 0) sense(XE_NONE);
    end
    sense(XE_UNCORRECT);
    for (int m = 2; m < 8; m++) begin
      lba = 28'($urandom);
      err_at <= go_count + 9'h3;
      err_code <= 3'(m);
      cmd(m[0] ? OP_VERIFY_B : OP_VERIFY_A, 8'h05, lba, 4'hE);
      wait_irq(16'h0002);
      rd(ADDR_OPCODE, v);
      chk("verify fail status", 16'h0041, v & 16'h00C9);
      rd(ADDR_COUNT, v);
      chk("unverified", 16'h0003, v & 16'h00FF);
      chk_addr(lba + 28'h2);
      sense(xe_of(3'(m)));
    end
    sense(XE_NONE);
    lba = {4'h0, 24'($urandom)};
    err_at <= go_count + 9'h100;
    err_code <= MERR_CORRECTED;
    cmd(OP_VERIFY_A, 8'h00, lba, 4'hE);
    wait_irq(16'h0002);
    rd(ADDR_OPCODE, v);
    chk("verify end status", 16'h0040, v & 16'h00C9);
    chk_addr(lba + 28'hFF);
    sense(XE_CORRECTED);
    wr(ADDR_MEDIA_CTRL, 16'h0000);
    cmd(OP_READ_A, 8'h01, lba, 4'hE);
    wait_irq(16'h0002);
    sense(XE_ABORTED);
    wr(ADDR_MEDIA_CTRL, 16'h0001);
    cmd(8'h55, 8'h01, lba, 4'hE);
    wait_irq(16'h0002);
    sense(XE_INVALID_CMD);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_IRQ_MASK, 16'h0000);
      cmd(k ? 8'h1F : 8'h10, 8'h01, 28'($urandom), k ? 4'hE : 4'hA);
      rd(ADDR_OPCODE, v);
      for (int i = 0; i < 50 && v[ST_BUSY_BIT] !== 1'b0; i++) rd(ADDR_OPCODE, v);
      chk("masked irq", 0, IRQ);
      wr(ADDR_IRQ_MASK, 16'h0003);
      wait_irq(16'h0002);
      chk("irq cleared", 0, IRQ);
      chk_addr(28'(k == 0));
    end
    wrap_up();
  end
endmodule : testbench
bind arce_engine arce_engine_chk arce_engine_chk_inst (.MCLK(MCLK), .RESET(RESET),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MEDIA_GO(MEDIA_GO),
  .MEDIA_LBA(MEDIA_LBA), .MEDIA_LONG(MEDIA_LONG), .MEDIA_WORD(MEDIA_WORD),
  .MEDIA_INDEX(MEDIA_INDEX), .IRQ(IRQ));
